// File: flash_bus_config_banking.sv
// Flash bus configuration, code banking, size decode and flash clock divider
// How it works
// - With fast read off, every normal read holds the flash bus for at least two flash clocks.
// - With fast read on, a normal read finishes in one flash clock.
// - With idle-before set, a cycle whose zone differs from the last one gets one idle clock ahead of it.
// - With idle-after set, one idle clock follows a cycle when the next cycle goes to another zone.
// - The bank select register picks the upper code bank only while the banking source option is one.
// - A code fetch with address bit 15 low goes to the common bank, otherwise to the selected bank.
// - The common bank maps to flash 00_0000h through 00_7FFFh.
// - Banks zero to three map to consecutive 32K regions from 00_8000h up to 02_7FFFh.
// - The two-bit bank field picks banks zero to three by its binary value, reset 00b.
// - The six-bit size field, reset 111111b, selects 4M down to 128K by thermometer code.
// - The flash clock is the core clock divided by the prescaler value plus one.
// - The four-bit prescaler takes 0 to 15 and resets to zero.
// - With fast read on, the wait count has no effect on read timing.
// - With the banking source option zero, the bank comes from two port-1 bits of the core.
`timescale 1ns/1ps
module flash_bus_config_banking (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic req_valid_i,
    input wire flash_cfg_pkg::flash_req_t req_i,
    input wire logic [1:0] port1_bank_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output logic [7:0] rsp_data_o,
    output logic flash_tick_o,
    output logic flash_rd_o,
    output logic [flash_cfg_pkg::FLASH_ADDR_W-1:0] flash_addr_o,
    input wire logic [7:0] flash_data_i
);
    import flash_cfg_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_GAP, ST_READ} state_t;

    function automatic logic [FLASH_ADDR_W-1:0] code_map(input logic [15:0] a, input logic [1:0] bank);
        logic [2:0] region;
        region = 3'h0;
        if (a[COMMON_BANK_BIT]) begin
            region = {1'b0, bank} + 3'h1;
        end
        code_map = {4'h0, region, a[14:0]};
    endfunction

    function automatic logic [FLASH_ADDR_W-1:0] size_mask(input logic [5:0] code);
        logic [FLASH_ADDR_W-1:0] m;
        m = '1;
        unique case (code)
            SIZE_2M: m = 22'h1fffff;
            SIZE_1M: m = 22'h0fffff;
            SIZE_512K: m = 22'h07ffff;
            SIZE_256K: m = 22'h03ffff;
            SIZE_128K: m = 22'h01ffff;
            default: m = '1;
        endcase
        size_mask = m;
    endfunction

    // Registers
    logic banking_source_option_r;
    logic [2:0] wait_state_count_r;
    logic fast_read_enable_r;
    logic idle_before_zone_change_r;
    logic idle_after_zone_change_r;
    logic [1:0] code_bank_number_r;
    logic [5:0] flash_size_code_r;
    logic [3:0] flash_clock_divider_r;
    logic ack_r;

    // Bus decode
    wire logic [7:0] reg_idx = adr_i[9:2];
    wire logic bus_req = cyc_i && stb_i && !ack_r;
    wire logic wr_byte0 = bus_req && we_i && sel_i[0] && ce_i;
    wire logic wr_program = wr_byte0 && (reg_idx == IDX_PROGRAM_CONFIG);
    wire logic wr_zone = wr_byte0 && (reg_idx == IDX_ZONE_CONFIG);
    wire logic wr_static = wr_byte0 && (reg_idx == IDX_STATIC_ZONE_CONFIG);
    wire logic wr_bank = wr_byte0 && (reg_idx == IDX_CODE_BANK_SELECT);
    wire logic wr_size = wr_byte0 && (reg_idx == IDX_FLASH_SIZE_SELECT);
    wire logic wr_div = wr_byte0 && (reg_idx == IDX_FLASH_CLOCK_PRESCALER);

    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        unique case (reg_idx)
            IDX_PROGRAM_CONFIG: rd_byte[BIT_BANKING_SOURCE] = banking_source_option_r;
            IDX_ZONE_CONFIG: rd_byte[2:0] = wait_state_count_r;
            IDX_STATIC_ZONE_CONFIG: begin
                rd_byte[BIT_FAST_READ] = fast_read_enable_r;
                rd_byte[BIT_IDLE_BEFORE] = idle_before_zone_change_r;
                rd_byte[BIT_IDLE_AFTER] = idle_after_zone_change_r;
            end
            IDX_CODE_BANK_SELECT: rd_byte[1:0] = code_bank_number_r;
            IDX_FLASH_SIZE_SELECT: rd_byte[5:0] = flash_size_code_r;
            IDX_FLASH_CLOCK_PRESCALER: rd_byte[3:0] = flash_clock_divider_r;
            default: rd_byte = 8'h00;
        endcase
    end

    assign ack_o = ack_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_r <= bus_req;
            dat_o <= {24'h00_0000, rd_byte};
        end
    end

    // Banking source option
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            banking_source_option_r <= RST_BANKING_SOURCE;
        end else if (wr_program) begin
            banking_source_option_r <= dat_i[BIT_BANKING_SOURCE];
        end
    end

    // Wait count
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wait_state_count_r <= RST_WAIT_COUNT;
        end else if (wr_zone) begin
            wait_state_count_r <= dat_i[2:0];
        end
    end

    // Static zone timing bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fast_read_enable_r <= RST_FAST_READ;
            idle_before_zone_change_r <= RST_IDLE_BEFORE;
            idle_after_zone_change_r <= RST_IDLE_AFTER;
        end else if (wr_static) begin
            fast_read_enable_r <= dat_i[BIT_FAST_READ];
            idle_before_zone_change_r <= dat_i[BIT_IDLE_BEFORE];
            idle_after_zone_change_r <= dat_i[BIT_IDLE_AFTER];
        end
    end

    // Code bank number
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            code_bank_number_r <= RST_BANK;
        end else if (wr_bank) begin
            code_bank_number_r <= dat_i[1:0];
        end
    end

    // Flash size code
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flash_size_code_r <= RST_SIZE;
        end else if (wr_size) begin
            flash_size_code_r <= dat_i[5:0];
        end
    end

    // Prescaler value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flash_clock_divider_r <= RST_DIVIDER;
        end else if (wr_div) begin
            flash_clock_divider_r <= dat_i[3:0];
        end
    end

    // Flash clock divider
    state_t state_r;
    state_t state_nxt;
    logic [3:0] div_cnt_r;
    logic [3:0] div_active_r;
    wire logic tick = (div_cnt_r == div_active_r);

    assign flash_tick_o = tick;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt_r <= 4'h0;
            div_active_r <= RST_DIVIDER;
        end else if (ce_i) begin
            if (tick) begin
                div_cnt_r <= 4'h0;
                if (state_nxt == ST_IDLE) begin
                    div_active_r <= flash_clock_divider_r;
                end
            end else begin
                div_cnt_r <= div_cnt_r + 4'h1;
            end
        end
    end

    // Request translation
    wire logic [1:0] bank_sel = banking_source_option_r ? code_bank_number_r : port1_bank_i;
    wire logic [FLASH_ADDR_W-1:0] mapped =
        req_i.code ? code_map(req_i.addr[15:0], bank_sel) : req_i.addr;
    wire logic [FLASH_ADDR_W-1:0] masked = mapped & size_mask(flash_size_code_r);

    // Sequencer
    timing_cfg_t cfg_r;
    timing_cfg_t cfg_now;
    logic [1:0] last_zone_r;
    logic after_pending_r;
    logic [3:0] cnt_r;
    wire logic zone_change = (req_i.zone != last_zone_r);

    // Settings captured when a cycle starts
    assign cfg_now.fast_read_enable = fast_read_enable_r;
    assign cfg_now.idle_before_zone_change = idle_before_zone_change_r;
    assign cfg_now.idle_after_zone_change = idle_after_zone_change_r;
    assign cfg_now.wait_state_count = wait_state_count_r;
    wire logic start = req_valid_i && (state_r == ST_IDLE);
    wire logic [1:0] gap_clocks =
        zone_change ? (2'({1'b0, idle_before_zone_change_r}) + 2'({1'b0, after_pending_r})) : 2'h0;
    wire logic [3:0] read_clocks = cfg_r.fast_read_enable ? FAST_READ_CLOCKS
        : NORMAL_READ_CLOCKS + {1'b0, cfg_r.wait_state_count};
    wire logic read_done = (state_r == ST_READ) && tick && (cnt_r == read_clocks - 4'h1);

    assign req_ready_o = (state_r == ST_IDLE);
    assign flash_rd_o = (state_r == ST_READ);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (start) begin
                    state_nxt = (gap_clocks != 2'h0) ? ST_GAP : ST_READ;
                end
            end
            ST_GAP: begin
                if (tick && (cnt_r == 4'h1)) begin
                    state_nxt = ST_READ;
                end
            end
            ST_READ: begin
                if (read_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
            cfg_r <= '0;
            last_zone_r <= 2'h0;
            flash_addr_o <= '0;
        end else if (ce_i) begin
            state_r <= state_nxt;
            if (start) begin
                cfg_r <= cfg_now;
                flash_addr_o <= masked;
                last_zone_r <= req_i.zone;
                cnt_r <= {2'h0, gap_clocks};
            end else if (state_r == ST_GAP && tick) begin
                cnt_r <= cnt_r - 4'h1;
            end else if (state_r == ST_READ && tick) begin
                cnt_r <= cnt_r + 4'h1;
            end
            if (state_r == ST_GAP && state_nxt == ST_READ) begin
                cnt_r <= 4'h0;
            end
            if (start && gap_clocks == 2'h0) begin
                cnt_r <= 4'h0;
            end
        end
    end

    // Response and pending idle-after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rsp_valid_o <= 1'b0;
            rsp_data_o <= 8'h00;
            after_pending_r <= 1'b0;
        end else if (ce_i) begin
            rsp_valid_o <= read_done;
            if (read_done) begin
                rsp_data_o <= flash_data_i;
                after_pending_r <= cfg_r.idle_after_zone_change;
            end
        end
    end
endmodule

// File: flash_cfg_pkg.sv
// Package with register map, field layout and types of the flash bus config block
package flash_cfg_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_PROGRAM_CONFIG = 8'h01;
    localparam logic [7:0] IDX_ZONE_CONFIG = 8'h02;
    localparam logic [7:0] IDX_STATIC_ZONE_CONFIG = 8'h03;
    localparam logic [7:0] IDX_CODE_BANK_SELECT = 8'h05;
    localparam logic [7:0] IDX_FLASH_SIZE_SELECT = 8'h07;
    localparam logic [7:0] IDX_FLASH_CLOCK_PRESCALER = 8'h10;
    // Field positions
    localparam int BIT_BANKING_SOURCE = 7;
    localparam int BIT_FAST_READ = 3;
    localparam int BIT_IDLE_BEFORE = 2;
    localparam int BIT_IDLE_AFTER = 1;
    // Reset values
    localparam logic RST_BANKING_SOURCE = 1'b1;
    localparam logic [2:0] RST_WAIT_COUNT = 3'h7;
    localparam logic RST_FAST_READ = 1'b0;
    localparam logic RST_IDLE_BEFORE = 1'b1;
    localparam logic RST_IDLE_AFTER = 1'b1;
    localparam logic [1:0] RST_BANK = 2'h0;
    localparam logic [5:0] RST_SIZE = 6'h3f;
    localparam logic [3:0] RST_DIVIDER = 4'h0;
    // Size codes
    localparam logic [5:0] SIZE_4M = 6'h3f;
    localparam logic [5:0] SIZE_2M = 6'h1f;
    localparam logic [5:0] SIZE_1M = 6'h0f;
    localparam logic [5:0] SIZE_512K = 6'h07;
    localparam logic [5:0] SIZE_256K = 6'h03;
    localparam logic [5:0] SIZE_128K = 6'h01;
    // Read timing in flash clocks
    localparam logic [3:0] FAST_READ_CLOCKS = 4'h1;
    localparam logic [3:0] NORMAL_READ_CLOCKS = 4'h2;
    localparam int FLASH_ADDR_W = 22;
    localparam int COMMON_BANK_BIT = 15;

    typedef struct packed {
        logic code;
        logic [1:0] zone;
        logic [FLASH_ADDR_W-1:0] addr;
    } flash_req_t;

    typedef struct packed {
        logic fast_read_enable;
        logic idle_before_zone_change;
        logic idle_after_zone_change;
        logic [2:0] wait_state_count;
    } timing_cfg_t;
endpackage

// File: flash_cfg_assertions.sv
// Port checker for the flash bus configuration block
`timescale 1ns/1ps
module flash_cfg_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic req_valid_i,
    input wire logic req_ready_o,
    input wire logic rsp_valid_o,
    input wire logic flash_rd_o,
    input wire logic [21:0] flash_addr_o
);
    wire take = req_valid_i && req_ready_o && ce_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_bus;
        cyc_i && stb_i && !ack_o && ce_i;
    endsequence
    sequence s_take;
        take;
    endsequence
    sequence s_answer;
        !rsp_valid_o ##[1:250] rsp_valid_o;
    endsequence
    ack_after_a: assert property (s_bus |=> ack_o) else $error("no ack after request");
    ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    rdata_upper_a: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("read data upper bits set");
    take_busy_a: assert property (s_take |=> !req_ready_o) else $error("ready after take");
    rsp_bound_a: assert property (s_take |=> s_answer) else $error("no flash response");
    rsp_idle_a: assert property (rsp_valid_o |-> req_ready_o && !flash_rd_o) else $error("busy at response");
    rsp_pulse_a: assert property (rsp_valid_o |=> !rsp_valid_o) else $error("response too long");
    addr_hold_a: assert property (!take |=> $stable(flash_addr_o)) else $error("address moved");
    rd_busy_a: assert property (flash_rd_o |-> !req_ready_o) else $error("read while idle");
endmodule
bind flash_bus_config_banking flash_cfg_assertions i_chk(.*);

// File: flash_mem_model.sv
// Behavioural parallel flash answering reads with an address pattern
`timescale 1ns/1ps
module flash_mem_model (
    input wire logic clk_i,
    input wire logic rd_i,
    input wire logic [21:0] addr_i,
    output logic [7:0] data_o
);
    logic [7:0] last_r;
    wire [7:0] word = addr_i[7:0] ^ addr_i[15:8];
    always_ff @(posedge clk_i) begin
        last_r <= data_o;
    end
    // Released bus toggles so stale data is never mistaken for valid
    assign data_o = rd_i ? word : ~last_r;
endmodule

// File: flash_bus_config_banking_tb.sv
// Random and corner tests of the flash bus configuration block
`timescale 1ns/1ps
module flash_bus_config_banking_tb;
    import flash_cfg_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, req_valid_i = 0;
    logic [9:0] adr_i = '0;
    logic [31:0] dat_i = '0;
    flash_req_t req_i = '0;
    logic [1:0] port1_bank_i = '0;
    wire [31:0] dat_o;
    wire ack_o, req_ready_o, rsp_valid_o, flash_tick_o, flash_rd_o;
    wire [7:0] rsp_data_o, flash_data_i;
    wire [21:0] flash_addr_o;
    int errors = 0, comparisons = 0, cyc_cnt = 0;
    always #20 clk_i = ~clk_i;
    flash_bus_config_banking i_dut(.clk_i, .rst_i, .ce_i(1'b1), .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'hf),
        .dat_i, .dat_o, .ack_o, .req_valid_i, .req_i, .port1_bank_i, .req_ready_o, .rsp_valid_o,
        .rsp_data_o, .flash_tick_o, .flash_rd_o, .flash_addr_o, .flash_data_i);
    flash_mem_model i_mem(.clk_i, .rd_i(flash_rd_o), .addr_i(flash_addr_o), .data_o(flash_data_i));
    task final_report;
        if (errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wb(input logic [7:0] idx, input logic w, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_i);
        cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= {idx, 2'b00}; dat_i <= {24'h0, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o[7:0];
        cyc_i <= 0; stb_i <= 0;
    endtask
    task fl(input logic c, input logic [1:0] z, input logic [21:0] a, input logic [21:0] ea, input int lat);
        int n;
        @(posedge clk_i);
        req_valid_i <= 1; req_i <= '{c, z, a};
        do @(posedge clk_i); while (req_ready_o !== 1'b1);
        req_valid_i <= 0;
        n = 0;
        do begin @(posedge clk_i); n++; end while (rsp_valid_o !== 1'b1);
        chk(n, lat);
        chk(flash_addr_o, ea);
        chk(rsp_data_o, ea[7:0] ^ ea[15:8]);
    endtask
    initial begin
        logic [7:0] q;
        logic [2:0] s, w;
        logic [1:0] z, lz, bk, p;
        logic lia, banking_source_option;
        logic [15:0] ca;
        logic [21:0] a, m;
        int k, n;
        void'($urandom(14));
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        wb(IDX_STATIC_ZONE_CONFIG, 0, 0, q); chk(q, 8'h06);
        wb(IDX_CODE_BANK_SELECT, 0, 0, q); chk(q, 8'h00);
        wb(IDX_FLASH_SIZE_SELECT, 0, 0, q); chk(q, 8'h3f);
        wb(IDX_FLASH_CLOCK_PRESCALER, 0, 0, q); chk(q, 8'h00);
        wb(8'h30, 0, 0, q); chk(q, 8'h00);
        for (k = 0; k < 6; k++) begin
            s = 0;
            p = 0;
            n = k == 0 ? 15 : k == 1 ? 0 : $urandom % 16;
            wb(IDX_FLASH_CLOCK_PRESCALER, 1, n[7:0], q);
            repeat (40) @(posedge clk_i);
            do @(posedge clk_i); while (flash_tick_o !== 1'b1);
            m = 0;
            do begin @(posedge clk_i); m++; end while (flash_tick_o !== 1'b1);
            chk(m, n + 1);
        end
        wb(IDX_FLASH_CLOCK_PRESCALER, 1, 8'h00, q);
        repeat (40) @(posedge clk_i);
        fl(0, 0, 22'h12345, 22'h12345, 10);
        lz = 0; lia = 1;
        for (k = 0; k < 24; k++) begin
            s = $urandom; w = $urandom; z = $urandom; a = $urandom;
            wb(IDX_STATIC_ZONE_CONFIG, 1, {4'h0, s, 1'b0}, q);
            wb(IDX_ZONE_CONFIG, 1, {5'h0, w}, q);
            fl(0, z, a, a, (z != lz ? int'(s[1]) + int'(lia) : 0) + (s[2] ? 1 : 2 + int'(w)) + 1);
            lz = z; lia = s[0];
        end
        wb(IDX_STATIC_ZONE_CONFIG, 1, 8'h08, q);
        for (k = 0; k < 24; k++) begin
            banking_source_option = $urandom; bk = $urandom; p = $urandom; ca = $urandom;
            if (k < 2) ca = k == 0 ? 16'h7fff : 16'h8000;
            port1_bank_i <= p;
            wb(IDX_PROGRAM_CONFIG, 1, {banking_source_option, 7'h7f}, q);
            wb(IDX_CODE_BANK_SELECT, 1, {6'h0, bk}, q);
            a = ca[15] ? {4'h0, {1'b0, banking_source_option ? bk : p} + 3'd1, ca[14:0]} : {7'h0, ca[14:0]};
            fl(1, lz, {6'h0, ca}, a, 2);
        end
        for (k = 0; k < 7; k++) begin
            m = k == 6 ? 22'h3fffff : 22'h3fffff >> k;
            s = 0;
            wb(IDX_FLASH_SIZE_SELECT, 1, k == 6 ? 8'h2a : 8'h3f >> k, q);
            wb(IDX_FLASH_SIZE_SELECT, 0, 0, q); chk(q, k == 6 ? 8'h2a : 8'h3f >> k);
            a = $urandom;
            fl(0, lz, a, a & m, 2);
        end
        final_report;
    end
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            errors++;
            final_report;
        end
    end
endmodule
